/* rtl/stop_mode_brake_sequencer.sv */
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Function
// - class-2 stop: coast, or zero-speed then coast
// - brake enabled forces class-2 mode one
// - overtravel stop: coast, zero-lock, zero-coast; default lock
// - class-1 fault always coasts, power removed
// - class-1 mode zero: coast, stay de-energised
// - wait 0-500 ms after brake on
// - ignore commands while that delay runs
// - stationary: brake off, wait 1-1000 ms, unpower
module stop_mode_brake_sequencer #(
  parameter int TICK_CYCLES = stop_brake_pkg::TICK_CYCLES,
  parameter int CMD_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic servoOn,
  input wire logic class1Fault,
  input wire logic class2Fault,
  input wire logic overtravel,
  input wire logic motorStationary,
  input wire logic cmdValid,
  input wire logic [CMD_WIDTH-1:0] cmdData,
  output logic cmdAccept,
  output logic cmdOutValid,
  output logic [CMD_WIDTH-1:0] cmdOut,
  output logic holdingBrakeOutput,
  output logic motorPowerOn,
  output logic zeroSpeedStop,
  output logic positionLock
);

  // ************************************************************
  // helpers
  // ************************************************************
  // merge the low two byte lanes of a write into a 16-bit value
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
    input logic [31:0] wdat, input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  // true when a value lies inside an allowed range
  function automatic logic inRange(input logic [15:0] v,
    input logic [15:0] lo, input logic [15:0] hi);
    return v >= lo && v <= hi;
  endfunction

  // ************************************************************
  // submodules
  // ************************************************************
  delay_if dl (); // tick and delay request

  ms_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dl(dl.ticker)
  );

  delay_timer u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dl(dl.timer)
  );

  // ************************************************************
  // register file
  // ************************************************************
  logic [15:0] class2Mode_q; // class-2 stop mode
  logic [15:0] otMode_q; // overtravel stop mode
  logic [15:0] class1Mode_q; // class-1 stop mode
  logic [15:0] onDelay_q; // brake on to command delay, ms
  logic [15:0] offDelay_q; // brake off to power off delay, ms
  logic brakeEn_q; // holding brake function enabled
  logic ack_q; // bus acknowledge
  logic [31:0] rdat_q; // read data
  logic busWrite; // write strobe this cycle
  logic [15:0] wval; // lane-merged write value
  logic [31:0] statusWord; // live status
  logic [15:0] class2Eff; // class-2 mode after forcing
  stop_brake_pkg::seq_state_t state_q; // sequencer state
  stop_brake_pkg::seq_state_t state_d; // next state

  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

  // pick the lane-merged value for the addressed register
  always_comb
  begin
    case (wb_adr_i)
      stop_brake_pkg::ADDR_CLASS2_MODE:
        wval = mergeLanes(class2Mode_q, wb_dat_i, wb_sel_i);
      stop_brake_pkg::ADDR_OT_MODE:
        wval = mergeLanes(otMode_q, wb_dat_i, wb_sel_i);
      stop_brake_pkg::ADDR_CLASS1_MODE:
        wval = mergeLanes(class1Mode_q, wb_dat_i, wb_sel_i);
      stop_brake_pkg::ADDR_ON_DELAY:
        wval = mergeLanes(onDelay_q, wb_dat_i, wb_sel_i);
      stop_brake_pkg::ADDR_OFF_DELAY:
        wval = mergeLanes(offDelay_q, wb_dat_i, wb_sel_i);
      default:
        wval = mergeLanes(16'h0000, wb_dat_i, wb_sel_i);
    endcase
  end

  // settings writes; out-of-range values leave the old setting
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      class2Mode_q <= stop_brake_pkg::CLASS2_MODE_RST;
      otMode_q <= stop_brake_pkg::OT_MODE_RST;
      class1Mode_q <= stop_brake_pkg::CLASS1_MODE_RST;
      onDelay_q <= stop_brake_pkg::ON_DELAY_RST;
      offDelay_q <= stop_brake_pkg::OFF_DELAY_RST;
      brakeEn_q <= 1'b0;
    end
    else if (busWrite)
    begin
      case (wb_adr_i)
        stop_brake_pkg::ADDR_CLASS2_MODE:
        begin
          if (inRange(wval, 16'h0000, stop_brake_pkg::CLASS2_MODE_MAX))
          begin
            class2Mode_q <= wval;
          end
        end
        stop_brake_pkg::ADDR_OT_MODE:
        begin
          if (inRange(wval, 16'h0000, stop_brake_pkg::OT_MODE_MAX))
          begin
            otMode_q <= wval;
          end
        end
        stop_brake_pkg::ADDR_CLASS1_MODE:
        begin
          if (inRange(wval, 16'h0000, stop_brake_pkg::CLASS1_MODE_MAX))
          begin
            class1Mode_q <= wval;
          end
        end
        stop_brake_pkg::ADDR_ON_DELAY:
        begin
          if (inRange(wval, stop_brake_pkg::ON_DELAY_MIN,
            stop_brake_pkg::ON_DELAY_MAX))
          begin
            onDelay_q <= wval;
          end
        end
        stop_brake_pkg::ADDR_OFF_DELAY:
        begin
          if (inRange(wval, stop_brake_pkg::OFF_DELAY_MIN,
            stop_brake_pkg::OFF_DELAY_MAX))
          begin
            offDelay_q <= wval;
          end
        end
        stop_brake_pkg::ADDR_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            brakeEn_q <= wb_dat_i[stop_brake_pkg::CTRL_BRAKE_EN_BIT];
          end
        end
        default:
        begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
  end

  // status word built from the live sequencer outputs
  always_comb
  begin
    statusWord = 32'h00000000;
    statusWord[stop_brake_pkg::STAT_STATE_LSB +: 4] = state_q;
    statusWord[stop_brake_pkg::STAT_BRAKE_BIT] = holdingBrakeOutput;
    statusWord[stop_brake_pkg::STAT_POWER_BIT] = motorPowerOn;
    statusWord[stop_brake_pkg::STAT_CMD_BIT] = cmdAccept;
    statusWord[stop_brake_pkg::STAT_DECEL_BIT] = zeroSpeedStop;
    statusWord[stop_brake_pkg::STAT_LOCK_BIT] = positionLock;
    statusWord[stop_brake_pkg::STAT_C2EFF_BIT] = class2Eff[0];
  end

  // one-cycle acknowledge with registered read data; unmapped reads 0
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      case (wb_adr_i)
        stop_brake_pkg::ADDR_CLASS2_MODE: rdat_q <= {16'h0000, class2Mode_q};
        stop_brake_pkg::ADDR_OT_MODE: rdat_q <= {16'h0000, otMode_q};
        stop_brake_pkg::ADDR_CLASS1_MODE: rdat_q <= {16'h0000, class1Mode_q};
        stop_brake_pkg::ADDR_ON_DELAY: rdat_q <= {16'h0000, onDelay_q};
        stop_brake_pkg::ADDR_OFF_DELAY: rdat_q <= {16'h0000, offDelay_q};
        stop_brake_pkg::ADDR_CTRL: rdat_q <= {31'h00000000, brakeEn_q};
        stop_brake_pkg::ADDR_STATUS: rdat_q <= statusWord;
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ************************************************************
  // stop sequencer
  // ************************************************************
  logic endLock_q; // zero-speed stop ends in position lock
  logic endLock_d; // next value
  logic anyFault; // any stop condition present

  // brake function forces zero-speed stop on a class-2 fault
  assign class2Eff = brakeEn_q ? stop_brake_pkg::C2_ZERO_COAST
    : class2Mode_q;
  assign anyFault = class1Fault || class2Fault || overtravel;

  // next state; priority class-1, class-2, overtravel, servo off
  always_comb
  begin
    state_d = state_q;
    endLock_d = endLock_q;
    dl.start = 1'b0;
    dl.loadMs = onDelay_q;
    case (state_q)
      stop_brake_pkg::ST_OFF:
      begin
        if (servoOn && !anyFault)
        begin
          state_d = stop_brake_pkg::ST_CMD_WAIT; // brake on, start delay
          dl.start = 1'b1;
          dl.loadMs = brakeEn_q ? onDelay_q : 16'h0000;
        end
      end
      stop_brake_pkg::ST_CMD_WAIT, stop_brake_pkg::ST_RUN,
      stop_brake_pkg::ST_HOLD:
      begin
        if (class1Fault)
        begin
          state_d = stop_brake_pkg::ST_STOPPED;
        end
        else if (class2Fault)
        begin
          if (class2Eff == stop_brake_pkg::MODE_COAST)
          begin
            state_d = stop_brake_pkg::ST_STOPPED;
          end
          else
          begin
            state_d = stop_brake_pkg::ST_DECEL;
            endLock_d = 1'b0;
          end
        end
        else if (overtravel && state_q != stop_brake_pkg::ST_HOLD)
        begin
          if (otMode_q == stop_brake_pkg::MODE_COAST)
          begin
            state_d = stop_brake_pkg::ST_STOPPED;
          end
          else
          begin
            state_d = stop_brake_pkg::ST_DECEL;
            endLock_d = otMode_q == stop_brake_pkg::MODE_ZERO_LOCK;
          end
        end
        else if (!servoOn && motorStationary)
        begin
          state_d = stop_brake_pkg::ST_BRAKE_WAIT;
          dl.start = 1'b1;
          dl.loadMs = brakeEn_q ? offDelay_q : 16'h0000;
        end
        else if (state_q == stop_brake_pkg::ST_HOLD && !overtravel)
        begin
          state_d = stop_brake_pkg::ST_RUN; // overtravel gone
        end
        else if (state_q == stop_brake_pkg::ST_CMD_WAIT && dl.done)
        begin
          state_d = stop_brake_pkg::ST_RUN;
        end
      end
      stop_brake_pkg::ST_DECEL:
      begin
        if (class1Fault)
        begin
          state_d = stop_brake_pkg::ST_STOPPED;
        end
        else if (motorStationary)
        begin
          if (endLock_q)
          begin
            state_d = stop_brake_pkg::ST_HOLD;
          end
          else
          begin
            state_d = stop_brake_pkg::ST_BRAKE_WAIT;
            dl.start = 1'b1;
            dl.loadMs = brakeEn_q ? offDelay_q : 16'h0000;
          end
        end
      end
      stop_brake_pkg::ST_BRAKE_WAIT:
      begin
        if (class1Fault || dl.done)
        begin
          state_d = stop_brake_pkg::ST_STOPPED;
        end
      end
      stop_brake_pkg::ST_STOPPED:
      begin
        if (!servoOn && !anyFault)
        begin
          state_d = stop_brake_pkg::ST_OFF; // unpowered until re-enabled
        end
      end
      default:
      begin
        state_d = stop_brake_pkg::ST_STOPPED;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= stop_brake_pkg::ST_OFF;
      endLock_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      endLock_q <= endLock_d;
    end
  end

  // drive outputs registered from the next state
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      holdingBrakeOutput <= 1'b0;
      motorPowerOn <= 1'b0;
      zeroSpeedStop <= 1'b0;
      positionLock <= 1'b0;
    end
    else
    begin
      holdingBrakeOutput <= brakeEn_q && state_d inside
        {stop_brake_pkg::ST_CMD_WAIT, stop_brake_pkg::ST_RUN,
        stop_brake_pkg::ST_DECEL, stop_brake_pkg::ST_HOLD};
      motorPowerOn <= !(state_d inside {stop_brake_pkg::ST_OFF,
        stop_brake_pkg::ST_STOPPED});
      zeroSpeedStop <= state_d == stop_brake_pkg::ST_DECEL;
      positionLock <= state_d == stop_brake_pkg::ST_HOLD;
    end
  end

  // ************************************************************
  // command gate
  // ************************************************************
  // commands pass only in run; dropped during the on delay
  assign cmdAccept = state_q == stop_brake_pkg::ST_RUN;

  // register accepted commands
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmdOutValid <= 1'b0;
      cmdOut <= '0;
    end
    else
    begin
      cmdOutValid <= cmdValid && cmdAccept;
      if (cmdValid && cmdAccept)
      begin
        cmdOut <= cmdData;
      end
    end
  end

endmodule

/* rtl/stop_brake_pkg.sv */
package stop_brake_pkg;

  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] ADDR_CLASS2_MODE = 8'h00; // class-2 stop mode
  localparam logic [7:0] ADDR_OT_MODE = 8'h04; // overtravel stop mode
  localparam logic [7:0] ADDR_CLASS1_MODE = 8'h08; // class-1 stop mode
  localparam logic [7:0] ADDR_ON_DELAY = 8'h0C; // brake on to command
  localparam logic [7:0] ADDR_OFF_DELAY = 8'h10; // brake off to power off
  localparam logic [7:0] ADDR_CTRL = 8'h14; // control bits
  localparam logic [7:0] ADDR_STATUS = 8'h18; // live status

  // ************************************************************
  // value ranges and reset values
  // ************************************************************
  localparam logic [15:0] CLASS2_MODE_MAX = 16'h0001;
  localparam logic [15:0] OT_MODE_MAX = 16'h0002;
  localparam logic [15:0] CLASS1_MODE_MAX = 16'h0000;
  localparam logic [15:0] ON_DELAY_MIN = 16'h0000;
  localparam logic [15:0] ON_DELAY_MAX = 16'h01F4;
  localparam logic [15:0] OFF_DELAY_MIN = 16'h0001;
  localparam logic [15:0] OFF_DELAY_MAX = 16'h03E8;
  localparam logic [15:0] CLASS2_MODE_RST = 16'h0000;
  localparam logic [15:0] OT_MODE_RST = 16'h0001;
  localparam logic [15:0] CLASS1_MODE_RST = 16'h0000;
  localparam logic [15:0] ON_DELAY_RST = 16'h00FA;
  localparam logic [15:0] OFF_DELAY_RST = 16'h0096;

  // stop mode encodings
  localparam logic [15:0] MODE_COAST = 16'h0000;
  localparam logic [15:0] MODE_ZERO_LOCK = 16'h0001;
  localparam logic [15:0] MODE_ZERO_COAST = 16'h0002;
  localparam logic [15:0] C2_ZERO_COAST = 16'h0001;

  // control and status fields
  localparam int CTRL_BRAKE_EN_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_BRAKE_BIT = 4;
  localparam int STAT_POWER_BIT = 5;
  localparam int STAT_CMD_BIT = 6;
  localparam int STAT_DECEL_BIT = 7;
  localparam int STAT_LOCK_BIT = 8;
  localparam int STAT_C2EFF_BIT = 9;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10; // ref_clk period
  localparam int TICK_PERIOD_NS = 1000000; // one millisecond
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // sequencer states
  typedef enum logic [3:0] {
    ST_OFF,
    ST_CMD_WAIT,
    ST_RUN,
    ST_DECEL,
    ST_HOLD,
    ST_BRAKE_WAIT,
    ST_STOPPED
  } seq_state_t;

endpackage

/* rtl/delay_if.sv */
`timescale 1ns/10ps
// carries the millisecond tick and one delay request between modules
interface delay_if;
  logic tick; // one-cycle pulse each millisecond
  logic start; // load and start the delay
  logic [15:0] loadMs; // delay length in milliseconds
  logic done; // pulse: delay has elapsed, high for one cycle
  logic busy; // level: delay is counting
  modport ticker (output tick);
  modport timer (input tick, input start, input loadMs, output done,
    output busy);
  modport owner (input done, input busy, output start, output loadMs);
endinterface

/* rtl/ms_tick_gen.sv */
`timescale 1ns/10ps
module ms_tick_gen #(
  parameter int TICK_CYCLES = stop_brake_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  delay_if.ticker dl
);

  // ************************************************************
  // millisecond divider
  // ************************************************************
  logic [31:0] count_q; // cycles since last tick
  logic tick_q; // registered tick

  // count cycles and pulse once per period
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else if (count_q == 32'(TICK_CYCLES - 1))
    begin
      count_q <= 32'h00000000;
      tick_q <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  assign dl.tick = tick_q;

endmodule

/* rtl/delay_timer.sv */
`timescale 1ns/10ps
module delay_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  delay_if.timer dl
);

  // ************************************************************
  // millisecond down counter
  // ************************************************************
  logic [15:0] count_q; // milliseconds left
  logic busy_q; // counting

  // load on start, count down on each tick
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= 16'h0000;
      busy_q <= 1'b0;
    end
    else if (dl.start)
    begin
      // one tick more: the first tick may come at once
      count_q <= dl.loadMs + {15'h0000, dl.loadMs != 16'h0000};
      busy_q <= 1'b1;
    end
    else if (busy_q && count_q == 16'h0000)
    begin
      busy_q <= 1'b0; // done seen for one cycle
    end
    else if (busy_q && dl.tick)
    begin
      count_q <= count_q - 16'h0001;
    end
  end

  assign dl.busy = busy_q;
  assign dl.done = busy_q && count_q == 16'h0000 && !dl.start;

endmodule

/* bench/stop_brake_chk.sv */
`timescale 1ns/10ps
// ************************************************************
// port checker
// ************************************************************
module stop_brake_chk #(
  parameter int CMD_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic class1Fault,
  input wire logic cmdValid,
  input wire logic [CMD_WIDTH-1:0] cmdData,
  input wire logic cmdAccept,
  input wire logic cmdOutValid,
  input wire logic [CMD_WIDTH-1:0] cmdOut,
  input wire logic holdingBrakeOutput,
  input wire logic motorPowerOn,
  input wire logic zeroSpeedStop,
  input wire logic positionLock
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // request awaiting ack
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // class-1 fault on three edges
  sequence s_c1;
    class1Fault [*3];
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack too long");
  property p_cmd_drop;
    cmdValid && !cmdAccept |=> !cmdOutValid;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop)
    else $error("blocked cmd passed");
  property p_cmd_pass;
    cmdValid && cmdAccept |=> cmdOutValid && cmdOut == $past(cmdData);
  endproperty
  a_cmd_pass: assert property (p_cmd_pass)
    else $error("cmd not forwarded");
  property p_brake_first;
    $rose(holdingBrakeOutput) |-> !cmdAccept;
  endproperty
  a_brake_first: assert property (p_brake_first)
    else $error("cmd open at brake on");
  property p_c1_off;
    s_c1 |-> !motorPowerOn && !holdingBrakeOutput;
  endproperty
  a_c1_off: assert property (p_c1_off)
    else $error("power on in class-1");
  property p_c1_stay;
    class1Fault && !motorPowerOn |=> !motorPowerOn;
  endproperty
  a_c1_stay: assert property (p_c1_stay)
    else $error("power back in class-1");
  property p_off_wait;
    $fell(holdingBrakeOutput) && motorPowerOn |->
      (motorPowerOn || class1Fault) [*8];
  endproperty
  a_off_wait: assert property (p_off_wait)
    else $error("power off too soon");
  property p_lock_power;
    positionLock |-> motorPowerOn && !zeroSpeedStop;
  endproperty
  a_lock_power: assert property (p_lock_power)
    else $error("lock unpowered");
  property p_decel_power;
    zeroSpeedStop |-> motorPowerOn;
  endproperty
  a_decel_power: assert property (p_decel_power)
    else $error("decel unpowered");
endmodule

bind stop_mode_brake_sequencer stop_brake_chk #(
  .CMD_WIDTH(CMD_WIDTH)
) stop_brake_chk_inst (.*);

/* bench/motor_model.sv */
`timescale 1ns/10ps
// ************************************************************
// motor and power stage: moves on commands, coasts to rest
// ************************************************************
module motor_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic motorPowerOn,
  input wire logic zeroSpeedStop,
  input wire logic cmdOutValid,
  input wire logic [7:0] stopCycles,
  output logic motorStationary
);
  logic [7:0] coastQ; // cycles left until standstill
  // a command starts motion; decel or lost power runs it down
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      coastQ <= 8'h00;
      motorStationary <= 1'b1;
    end
    else if (motorPowerOn && cmdOutValid && !zeroSpeedStop)
    begin
      coastQ <= stopCycles;
      motorStationary <= 1'b0;
    end
    else if (!motorStationary && (zeroSpeedStop || !motorPowerOn))
    begin
      coastQ <= coastQ - 8'h01;
      motorStationary <= (coastQ <= 8'h01);
    end
  end
endmodule

/* bench/stop_mode_brake_sequencer_tb.sv */
`timescale 1ns/10ps
// ************************************************************
// bench with a register mirror
// ************************************************************
module stop_mode_brake_sequencer_tb;
  localparam int TK = 10; // cycles per millisecond tick here
  localparam logic [15:0] HI[5] = '{16'h0001, 16'h0002, 16'h0000,
    16'h01F4, 16'h03E8};
  localparam logic [15:0] LO[5] = '{16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0001};
  localparam logic [15:0] RST[5] = '{16'h0000, 16'h0001, 16'h0000,
    16'h00FA, 16'h0096};
  logic ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, stopCycles;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, cmdData, cmdOut, rnd, q;
  logic servoOn, class1Fault, class2Fault, overtravel, motorStationary;
  logic cmdValid, cmdAccept, cmdOutValid, holdingBrakeOutput;
  logic motorPowerOn, zeroSpeedStop, positionLock, brakeEn, isOt;
  logic [15:0] regv[5]; // mirror of the settings
  int n_fail, num_checks, c, m;

  stop_mode_brake_sequencer #(.TICK_CYCLES(TK), .CMD_WIDTH(32))
  stop_mode_brake_sequencer_inst (.*);
  motor_model motor_model_inst (.*);

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] next_rnd();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // classic cycle held until ack
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20)
    begin
      chk("ack", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  // write; mirror keeps in-range values
  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
    int i;
    i = adr >> 2;
    wb_cycle(1'b1, adr, d, q);
    if (i < 5 && d <= {16'h0000, HI[i]} && d >= {16'h0000, LO[i]})
      regv[i] = d[15:0];
    if (adr == stop_brake_pkg::ADDR_CTRL)
      brakeEn = d[0];
  endtask

  task automatic wb_rd_chk(input logic [7:0] adr);
    int i;
    i = adr >> 2;
    wb_cycle(1'b0, adr, 32'h0, q);
    chk($sformatf("reg%0h", adr),
      i < 5 ? {16'h0000, regv[i]} : (i == 5 ? {31'h0, brakeEn} : 32'h0), q);
  endtask

  // wait for an output level
  task automatic wait_sig(input int s, input logic lv, output int n);
    logic v;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      case (s)
        0: v = cmdAccept;
        1: v = zeroSpeedStop;
        2: v = positionLock;
        3: v = motorPowerOn;
        default: v = holdingBrakeOutput;
      endcase
    end
    while (v !== lv && n < 4000);
    if (v !== lv)
    begin
      chk($sformatf("wait%0d", s), 32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic restart(input logic brk);
    reset_n <= 1'b0;
    {servoOn, class1Fault, class2Fault, overtravel, cmdValid} <= 5'h00;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    regv = RST;
    brakeEn = 1'b0;
    wb_wr(stop_brake_pkg::ADDR_CTRL, {31'h0, brk});
  endtask

  task automatic send_cmd();
    logic [31:0] d;
    d = next_rnd();
    cmdValid <= 1'b1;
    cmdData <= d;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    @(posedge ref_clk);
    chk("cmdOutValid", 32'h1, {31'h0, cmdOutValid});
    chk("cmdOut", d, cmdOut);
  endtask

  // main sequence
  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, cmdValid} = 5'h00;
    {servoOn, class1Fault, class2Fault, overtravel} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cmdData} = 76'h0;
    wb_sel_i = 4'h3;
    stopCycles = 8'h10;
    rnd = 32'h00011217;
    n_fail = 0;
    num_checks = 0;
    restart(1'b0);
    for (int i = 0; i < 8; i++)
      if (i != 6)
        wb_rd_chk(8'(i * 4));
    for (int i = 0; i < 5; i++)
    begin
      wb_wr(8'(i * 4), {16'h0000, HI[i] + 16'h0001});
      wb_wr(8'(i * 4), LO[i] + next_rnd() % (HI[i] - LO[i] + 1));
    end
    wb_wr(stop_brake_pkg::ADDR_OFF_DELAY, 32'h0);
    wb_wr(8'h1C, next_rnd());
    for (int i = 0; i < 8; i++)
      if (i != 6)
        wb_rd_chk(8'(i * 4));
    // brake on: command delay, forced class-2 decel
    restart(1'b1);
    wb_wr(stop_brake_pkg::ADDR_ON_DELAY, 32'h3);
    wb_wr(stop_brake_pkg::ADDR_OFF_DELAY, 32'h2);
    servoOn <= 1'b1;
    cmdValid <= 1'b1;
    cmdData <= next_rnd();
    wait_sig(4, 1'b1, c);
    wait_sig(0, 1'b1, c);
    chk("onDelay", 32'h1, {31'h0, c >= 3 * TK - 2 && c <= 4 * TK + 4});
    cmdValid <= 1'b0;
    @(posedge ref_clk);
    send_cmd();
    stopCycles <= 8'h20;
    class2Fault <= 1'b1;
    wait_sig(1, 1'b1, c);
    wb_cycle(1'b0, stop_brake_pkg::ADDR_STATUS, 32'h0, q);
    chk("effClass2", 32'h1, {31'h0, q[9]});
    wait_sig(4, 1'b0, c);
    wait_sig(3, 1'b0, c);
    chk("offDelay", 32'h1, {31'h0, c >= 2 * TK - 3 && c <= 3 * TK + 4});
    // class-2 and overtravel modes with brake disabled
    for (int k = 0; k < 5; k++)
    begin
      isOt = k > 1;
      m = isOt ? k - 2 : k;
      restart(1'b0);
      wb_wr(isOt ? stop_brake_pkg::ADDR_OT_MODE :
        stop_brake_pkg::ADDR_CLASS2_MODE, m);
      stopCycles <= 8'(2 + next_rnd() % 30);
      servoOn <= 1'b1;
      wait_sig(0, 1'b1, c);
      send_cmd();
      overtravel <= isOt;
      class2Fault <= !isOt;
      if (m == 0)
      begin
        wait_sig(3, 1'b0, c);
        chk("coastOff", 32'h1, {31'h0, c <= 3});
        chk("noDecel", 32'h0, {31'h0, zeroSpeedStop});
      end
      else
      begin
        wait_sig(1, 1'b1, c);
        chk("decelStart", 32'h1, {31'h0, c <= 3});
        if (isOt && m == 1)
        begin
          wait_sig(2, 1'b1, c);
          chk("lockPower", 32'h1, {31'h0, motorPowerOn});
          overtravel <= 1'b0;
          wait_sig(0, 1'b1, c);
        end
        else
          wait_sig(3, 1'b0, c);
      end
    end
    // class-1 overrides class-2, coasts unpowered
    restart(1'b1);
    wb_wr(stop_brake_pkg::ADDR_ON_DELAY, 32'h0);
    servoOn <= 1'b1;
    wait_sig(0, 1'b1, c);
    send_cmd();
    class1Fault <= 1'b1;
    class2Fault <= 1'b1;
    wait_sig(3, 1'b0, c);
    chk("c1Fast", 32'h1, {31'h0, c <= 3});
    repeat (5) @(posedge ref_clk);
    chk("c1State", 32'h0, {29'h0, motorPowerOn, holdingBrakeOutput,
      zeroSpeedStop});
    complete_run();
  end
endmodule
